//--- design/pofc_top.sv
// Operand form configuration register with AXI4-Lite slave and per-operation latch
module pofc_top
    import pofc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic op_start,
    input wire logic op_done,
    output logic in0_affine_sel,
    output logic in0_montgomery_sel,
    output logic in1_affine_sel,
    output logic in1_montgomery_sel,
    output logic out_affine_sel,
    output logic out_montgomery_sel,
    output logic op_busy
);
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    // Write channel state
    logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
    logic [ADDR_W-1:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d;
    logic [7:0] cfg_q, cfg_d;
    logic wr_fire;

    always_comb
    begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        cfg_d = cfg_q;
        wr_fire = 1'b0;
        if (s_axi_awvalid && !aw_got_q && !bvalid_q)
        begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_q && !bvalid_q)
        begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (aw_got_q && w_got_q)
        begin
            wr_fire = 1'b1;
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            if (addr_hit(awaddr_q, OFF_FORM_CFG))
            begin
                bresp_d = RESP_OKAY;
                if (wstrb_q[0])
                begin
                    cfg_d = wdata_q[7:0] & FORM_CFG_MASK;
                end
            end
            else if (addr_hit(awaddr_q, OFF_FORM_ACTIVE))
            begin
                bresp_d = RESP_OKAY;
            end
            else
            begin
                bresp_d = RESP_SLVERR;
            end
        end
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            cfg_q <= FORM_CFG_RESET;
        end
        else
        begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            cfg_q <= cfg_d;
        end
    end

    // Active format latch; software writes land only in cfg_q until next start taken in POFC_IDLE
    pofc_state_t state_q, state_d;
    logic [7:0] act_q, act_d;
    logic busy_q, busy_d;

    always_comb
    begin
        state_d = state_q;
        act_d = act_q;
        case (state_q)
            POFC_IDLE:
            begin
                if (op_start)
                begin
                    act_d = cfg_q;
                    state_d = POFC_RUN;
                end
            end
            POFC_RUN:
            begin
                if (op_done)
                begin
                    state_d = POFC_IDLE;
                end
            end
            default:
            begin
                state_d = POFC_IDLE;
            end
        endcase
        // Registered so the busy pin comes straight from a flop
        busy_d = (state_d == POFC_RUN);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= POFC_IDLE;
            act_q <= FORM_CFG_RESET;
            busy_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            act_q <= act_d;
            busy_q <= busy_d;
        end
    end

    // Read channel
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;

    always_comb
    begin
        arready_d = 1'b0;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && !rvalid_q && !arready_q)
        begin
            arready_d = 1'b1;
            rvalid_d = 1'b1;
            rdata_d = '0;
            rresp_d = RESP_OKAY;
            if (addr_hit(s_axi_araddr, OFF_FORM_CFG))
            begin
                rdata_d[7:0] = cfg_q;
            end
            else if (addr_hit(s_axi_araddr, OFF_FORM_ACTIVE))
            begin
                rdata_d[7:0] = act_q;
                rdata_d[BIT_BUSY] = (state_q == POFC_RUN);
            end
            else
            begin
                rresp_d = RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_awready = aw_got_q;
    assign s_axi_wready = w_got_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign in0_affine_sel = act_q[BIT_IN0_AFF];
    assign in0_montgomery_sel = act_q[BIT_IN0_MON];
    assign in1_affine_sel = act_q[BIT_IN1_AFF];
    assign in1_montgomery_sel = act_q[BIT_IN1_MON];
    assign out_affine_sel = act_q[BIT_OUT_AFF];
    assign out_montgomery_sel = act_q[BIT_OUT_MON];
    assign op_busy = busy_q;

    a_cfg_capture: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (act_q == $past(cfg_q)))
        else $error("format not captured at start");
    a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_RUN) |=> (act_q == $past(act_q)))
        else $error("format changed mid operation");
    a_in0_aff: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (in0_affine_sel == $past(cfg_q[BIT_IN0_AFF])))
        else $error("in0 affine select wrong");
    a_in0_mon: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (in0_montgomery_sel == $past(cfg_q[BIT_IN0_MON])))
        else $error("in0 montgomery select wrong");
    a_in1_aff: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (in1_affine_sel == $past(cfg_q[BIT_IN1_AFF])))
        else $error("in1 affine select wrong");
    a_in1_mon: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (in1_montgomery_sel == $past(cfg_q[BIT_IN1_MON])))
        else $error("in1 montgomery select wrong");
    a_out_aff: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (out_affine_sel == $past(cfg_q[BIT_OUT_AFF])))
        else $error("out affine select not taken");
    a_out_mon: assert property (@(posedge clk) disable iff (!rst_b)
        (state_q == POFC_IDLE && op_start) |=> (out_montgomery_sel == $past(cfg_q[BIT_OUT_MON])))
        else $error("out montgomery select not taken");
    a_write_cfg: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_fire && addr_hit(awaddr_q, OFF_FORM_CFG) && wstrb_q[0])
        |=> (cfg_q == ($past(wdata_q[7:0]) & FORM_CFG_MASK)) && bvalid_q)
        else $error("config write lost");
endmodule

//--- inc/pofc_pkg.sv
// Package: register map, field positions and enumerations for the operand form config block
package pofc_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam logic [ADDR_W-1:0] OFF_FORM_CFG = 16'h2050;
    localparam logic [ADDR_W-1:0] OFF_FORM_ACTIVE = 16'h2054;
    localparam logic [7:0] FORM_CFG_RESET = 8'h2A;
    localparam logic [7:0] FORM_CFG_MASK = 8'h3F;
    localparam int unsigned BIT_IN0_AFF = 0;
    localparam int unsigned BIT_IN0_MON = 1;
    localparam int unsigned BIT_IN1_AFF = 2;
    localparam int unsigned BIT_IN1_MON = 3;
    localparam int unsigned BIT_OUT_AFF = 4;
    localparam int unsigned BIT_OUT_MON = 5;
    localparam int unsigned BIT_BUSY = 8;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic {POFC_IDLE, POFC_RUN} pofc_state_t;
endpackage

//--- tb/pofc_top_tb_top.sv
// Bench for the operand form config block: AXI4-Lite access and per-operation latch
module pofc_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pofc_pkg::*;
    logic clk = 0, rst_b = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, start = 0, done = 0;
    logic awr, wr_r, bv, arr, rv, busy;
    logic [15:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rd_d, seed = 32'h3345, v;
    logic [3:0] ws = 0;
    logic [1:0] br, rr, resp;
    logic [5:0] sel;
    int failures = 0, total_checks = 0, cyc = 0;
    pofc_top dut_u (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .op_start(start),
        .op_done(done), .in0_affine_sel(sel[0]), .in0_montgomery_sel(sel[1]), .in1_affine_sel(sel[2]),
        .in1_montgomery_sel(sel[3]), .out_affine_sel(sel[4]), .out_montgomery_sel(sel[5]), .op_busy(busy));
    initial
    begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Only bits 5:0 hold state; the rest read back zero
    function automatic logic [31:0] exp_cfg(input logic [31:0] d);
        return {24'h0, d[7:0] & FORM_CFG_MASK};
    endfunction
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Valids drop only at the edge where their ready is seen
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        awa <= a; wd <= d; ws <= s; awv <= 1; wv <= 1; brdy <= 1;
        do
        begin
            @(posedge clk);
            if (awr === 1'b1) awv <= 0;
            if (wr_r === 1'b1) wv <= 0;
        end while (bv !== 1'b1);
        resp = br;
        brdy <= 0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        ara <= a; arv <= 1; rrdy <= 1;
        do
        begin
            @(posedge clk);
            if (arr === 1'b1) arv <= 0;
        end while (rv !== 1'b1);
        resp = rr;
        v = rd_d;
        rrdy <= 0;
    endtask
    task automatic pulse(input bit is_start);
        @(posedge clk);
        if (is_start) start <= 1; else done <= 1;
        @(posedge clk);
        start <= 0; done <= 0;
        @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            results();
        end
    end
    initial
    begin
        logic [31:0] cfg, act_exp;
        act_exp = exp_cfg({24'h0, FORM_CFG_RESET});
        repeat (20) @(posedge clk);
        rst_b <= 1;
        chk(sel, FORM_CFG_RESET[5:0]);
        chk(busy, 1'b0);
        rd(OFF_FORM_CFG);
        chk(v, FORM_CFG_RESET);
        $display("reset test done");
        for (int i = 0; i < 16; i++)
        begin
            seed = lfsr(seed);
            cfg = (i == 0) ? 32'hFF : (i == 1) ? 32'h0 : seed;
            wr(OFF_FORM_CFG, cfg, 4'hF);
            chk(resp, RESP_OKAY);
            rd(OFF_FORM_CFG);
            chk(v, exp_cfg(cfg));
            chk(sel, act_exp);
            pulse(1);
            act_exp = exp_cfg(cfg);
            chk(busy, 1'b1);
            chk(sel, act_exp);
            wr(OFF_FORM_CFG, ~cfg, 4'hF);
            pulse(1);
            chk(sel, act_exp);
            rd(OFF_FORM_ACTIVE);
            chk(v, act_exp | 32'h100);
            pulse(0);
            chk(busy, 1'b0);
        end
        $display("format latch test done");
        wr(16'h2100, 32'h15, 4'hF);
        chk(resp, RESP_SLVERR);
        rd(16'h2100);
        chk(resp, RESP_SLVERR);
        chk(v, 32'h0);
        wr(OFF_FORM_CFG, 32'h15, 4'hF);
        wr(OFF_FORM_CFG, 32'h2A, 4'hE);
        chk(resp, RESP_OKAY);
        rd(OFF_FORM_CFG);
        chk(v, 32'h15);
        pulse(1);
        chk(sel, 6'h15);
        pulse(0);
        $display("refusal test done");
        results();
    end
endmodule
